// ==== logic/ufa_pkg.sv ====
// Purpose: constants and types for the serial port with framing error and address match
// Assumes: CLK_SYS is the oscillator clock that sets the fixed mode rates
// Notes:   register offsets are byte addresses on the special function register port
package ufa_pkg;
	// special function register addresses
	localparam logic [7:0] ADDR_PWR   = 8'h87;
	localparam logic [7:0] ADDR_SERIAL_CONTROL_REG  = 8'h98;
	localparam logic [7:0] ADDR_SBUF  = 8'h99;
	localparam logic [7:0] ADDR_SLAVE_ADDRESS = 8'hA9;
	localparam logic [7:0] ADDR_SLAVE_ADDRESS_MASK = 8'hB9;
	// power control bit positions
	localparam int PWR_DBL  = 7;
	localparam int PWR_FSEL = 6;
	// mode codes {mode bit 0, mode bit 1}
	localparam logic [1:0] MODE_SHIFT = 2'h0;
	localparam logic [1:0] MODE_UART8 = 2'h1;
	localparam logic [1:0] MODE_FIX9  = 2'h2;
	localparam logic [1:0] MODE_VAR9  = 2'h3;
	// rate dividers in oscillator clocks
	localparam logic [3:0] DIV_SHIFT  = 4'hC;
	localparam logic [3:0] SHIFT_HALF = 4'h6;
	localparam logic [3:0] DIV_FIX    = 4'h4;
	localparam logic [3:0] DIV_FIX_DB = 4'h2;
	// sample ticks per bit and bit counts
	localparam logic [3:0] OVS_LAST   = 4'hF;
	localparam logic [3:0] OVS_MID    = 4'h7;
	localparam logic [3:0] LAST_8     = 4'h9;
	localparam logic [3:0] LAST_9     = 4'hA;
	localparam logic [3:0] SHIFT_LAST = 4'h7;
	localparam logic [7:0] RST_BYTE   = 8'h00;
	// serial control register layout, mode bit 0 sits at bit 7
	typedef struct packed {
		logic sm0;
		logic sm1;
		logic sm2;
		logic ren;
		logic tb8;
		logic rb8;
		logic ri;
		logic ti;
	} ufa_serial_control_reg_s;
	// register port request
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} ufa_sfr_s;
	typedef enum logic [2:0] {TX_IDLE = 3'h1, TX_UART = 3'h2, TX_SHIFT = 3'h4} ufa_tx_e;
	typedef enum logic [2:0] {RX_IDLE = 3'h1, RX_UART = 3'h2, RX_SHIFT = 3'h4} ufa_rx_e;
endpackage

// ==== logic/ufa_uart.sv ====
// Purpose: four-mode serial port with framing error flag and address recognition
// Assumes: T1_OVF is a one-cycle pulse from a timer on CLK_SYS
// Notes:   reads answer on SFR_RDATA one clock after the read strobe
// Notes on behaviour
// - the doubler bit doubles the bit rate in the timer and fixed nine-bit modes.
// - bit 7 of serial control is the framing error flag when flag select is set, else mode bit 0.
// - a frame whose stop bit samples low sets the framing error flag.
// - the framing error flag stays set across good frames until software writes it clear.
// - mode 00 shifts at clock/12, 01 is 8-bit timer rate, 10 is 9-bit at clock/64 or /32, 11 is 9-bit timer rate.
// - in nine-bit modes with matching on, the receive flag rises only for ninth bit 1 and a matching byte.
// - in mode 1 with matching on, the receive flag rises only for a good stop bit and a matching byte.
// - shift mode ignores the match enable bit, which software keeps at 0 there.
// - frames are taken only while receive enable is 1, and clearing it stops reception.
// - nine-bit modes send the transmit ninth bit after the eighth data bit.
// - the receive ninth bit takes the ninth bit in nine-bit modes and the stop bit in mode 1 without matching.
// - the transmit flag sets after the eighth bit in shift mode and at stop bit start otherwise.
// - the receive flag sets after the eighth bit in shift mode and mid stop bit otherwise, subject to matching.
// - the given address is slave address and mask, mask zeros are ignored.
// - the broadcast address is slave address or mask, zeros in it are ignored.
// - slave address and mask reset to zero so every byte matches.
`timescale 1ns/1ps
module ufa_uart (
	input  wire logic             CLK_SYS,
	input  wire logic             NRST,
	input  wire ufa_pkg::ufa_sfr_s SFR_REQ,
	output logic [7:0]            SFR_RDATA,
	input  wire logic             T1_OVF,
	input  wire logic             RXD_IN,
	output logic                  RXD_OUT,
	output logic                  RXD_OE,
	output logic                  TXD_OUT
);
	ufa_pkg::ufa_serial_control_reg_s serial_control_reg, next_serial_control_reg;
	ufa_pkg::ufa_tx_e   tx_state, next_tx_state;
	ufa_pkg::ufa_rx_e   rx_state, next_rx_state;
	logic        fe, next_fe, dbl, next_dbl, fsel, next_fsel;
	logic [7:0]  slave_address, next_slave_address, slave_address_mask, next_slave_address_mask, sbuf_rx, next_sbuf_rx, next_rdata;
	logic [3:0]  div_cnt, next_div, tx_cnt, next_tx_cnt, tx_sub, next_tx_sub;
	logic [3:0]  rx_cnt, next_rx_cnt, rx_sub, next_rx_sub, tx_last;
	logic [10:0] tx_sh, next_tx_sh;
	logic [8:0]  rx_sh, next_rx_sh;
	logic        t1_half, next_t1h, tick, shift_en, nine, mode0, sbuf_wr;
	logic        next_txd, next_rxd_out, next_rxd_oe, tx_evt, rx_evt, fe_evt, rx_fin;
	logic        rx_s1, rx_s2, rx_s3, rx_b9, addr_match;
	logic [7:0]  rx_byte;
	logic [1:0]  mode;

	// mode decode and software strobes
	assign mode    = {serial_control_reg.sm0, serial_control_reg.sm1};
	assign nine    = serial_control_reg.sm0;
	assign mode0   = (mode == ufa_pkg::MODE_SHIFT);
	assign sbuf_wr = SFR_REQ.wr && (SFR_REQ.addr == ufa_pkg::ADDR_SBUF);
	assign tx_last = nine ? ufa_pkg::LAST_9 : ufa_pkg::LAST_8;

	// rate divider: shift enable in mode 0, sample tick otherwise
	always_comb begin
		next_div = div_cnt + 4'h1;
		next_t1h = t1_half;
		tick     = 1'b0;
		shift_en = 1'b0;
		case (mode)
			ufa_pkg::MODE_SHIFT: begin
				// held while idle so each transfer opens on a whole bit period
				if (tx_state == ufa_pkg::TX_IDLE && rx_state == ufa_pkg::RX_IDLE) begin
					next_div = 4'h0;
				end else if (div_cnt >= ufa_pkg::DIV_SHIFT - 4'h1) begin
					shift_en = 1'b1;
					next_div = 4'h0;
				end
			end
			ufa_pkg::MODE_FIX9: begin
				if (div_cnt >= (dbl ? ufa_pkg::DIV_FIX_DB : ufa_pkg::DIV_FIX) - 4'h1) begin
					tick     = 1'b1;
					next_div = 4'h0;
				end
			end
			default: begin
				next_div = 4'h0;
				if (T1_OVF) begin
					next_t1h = ~t1_half;
					tick     = dbl | t1_half;
				end
			end
		endcase
	end

	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			div_cnt <= 4'h0;
			t1_half <= 1'b0;
		end else begin
			div_cnt <= next_div;
			t1_half <= next_t1h;
		end
	end

	// transmitter, least significant bit first
	always_comb begin
		next_tx_state = tx_state;
		next_tx_sh    = tx_sh;
		next_tx_cnt   = tx_cnt;
		next_tx_sub   = tx_sub;
		tx_evt        = 1'b0;
		case (tx_state)
			ufa_pkg::TX_IDLE: begin
				if (sbuf_wr) begin
					next_tx_cnt = 4'h0;
					next_tx_sub = 4'h0;
					if (mode0) begin
						next_tx_sh    = {3'h7, SFR_REQ.wdata};
						next_tx_state = ufa_pkg::TX_SHIFT;
					end else begin
						next_tx_sh    = {1'b1, nine ? serial_control_reg.tb8 : 1'b1, SFR_REQ.wdata, 1'b0};
						next_tx_state = ufa_pkg::TX_UART;
					end
				end
			end
			ufa_pkg::TX_UART: begin
				if (tick) begin
					next_tx_sub = tx_sub + 4'h1;
					if (tx_sub == ufa_pkg::OVS_LAST) begin
						next_tx_sh  = {1'b1, tx_sh[10:1]};
						next_tx_cnt = tx_cnt + 4'h1;
						if (tx_cnt == tx_last)
							next_tx_state = ufa_pkg::TX_IDLE;
						else if (tx_cnt + 4'h1 == tx_last)
							tx_evt = 1'b1;
					end
				end
			end
			ufa_pkg::TX_SHIFT: begin
				if (shift_en) begin
					next_tx_sh  = {1'b1, tx_sh[10:1]};
					next_tx_cnt = tx_cnt + 4'h1;
					if (tx_cnt == ufa_pkg::SHIFT_LAST) begin
						tx_evt        = 1'b1;
						next_tx_state = ufa_pkg::TX_IDLE;
					end
				end
			end
			default: next_tx_state = ufa_pkg::TX_IDLE;
		endcase
		// pins: mode 0 drives data on the receive pin and the shift clock on transmit
		next_rxd_oe  = (next_tx_state == ufa_pkg::TX_SHIFT);
		next_rxd_out = next_rxd_oe ? next_tx_sh[0] : 1'b1;
		if (next_rxd_oe || next_rx_state == ufa_pkg::RX_SHIFT)
			next_txd = (next_div >= ufa_pkg::SHIFT_HALF);
		else
			next_txd = (next_tx_state == ufa_pkg::TX_UART) ? next_tx_sh[0] : 1'b1;
	end

	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			tx_state <= ufa_pkg::TX_IDLE;
			tx_sh    <= 11'h7FF;
			tx_cnt   <= 4'h0;
			tx_sub   <= 4'h0;
			TXD_OUT  <= 1'b1;
			RXD_OUT  <= 1'b1;
			RXD_OE   <= 1'b0;
		end else begin
			tx_state <= next_tx_state;
			tx_sh    <= next_tx_sh;
			tx_cnt   <= next_tx_cnt;
			tx_sub   <= next_tx_sub;
			TXD_OUT  <= next_txd;
			RXD_OUT  <= next_rxd_out;
			RXD_OE   <= next_rxd_oe;
		end
	end

	// receive pin synchroniser plus one stage for edge detect
	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			rx_s1 <= 1'b1;
			rx_s2 <= 1'b1;
			rx_s3 <= 1'b1;
		end else begin
			rx_s1 <= RXD_IN;
			rx_s2 <= rx_s1;
			rx_s3 <= rx_s2;
		end
	end

	// address recognition against given and broadcast addresses
	assign rx_byte    = mode0 ? {rx_s2, rx_sh[8:2]} : (nine ? rx_sh[7:0] : rx_sh[8:1]);
	assign rx_b9      = nine ? rx_sh[8] : rx_s2;
	assign addr_match = (((rx_byte ^ slave_address) & slave_address_mask) == 8'h00)
		|| ((rx_byte & (slave_address | slave_address_mask)) == (slave_address | slave_address_mask));

	// receiver: start edge, mid-bit samples, finish at mid stop bit
	always_comb begin
		next_rx_state = rx_state;
		next_rx_sh    = rx_sh;
		next_rx_cnt   = rx_cnt;
		next_rx_sub   = rx_sub;
		rx_fin        = 1'b0;
		rx_evt        = 1'b0;
		case (rx_state)
			ufa_pkg::RX_IDLE: begin
				next_rx_cnt = 4'h0;
				next_rx_sub = 4'h0;
				if (mode0 && !serial_control_reg.ri && tx_state == ufa_pkg::TX_IDLE && !sbuf_wr)
					next_rx_state = ufa_pkg::RX_SHIFT;
				else if (!mode0 && rx_s3 && !rx_s2)
					next_rx_state = ufa_pkg::RX_UART;
			end
			ufa_pkg::RX_UART: begin
				if (tick) begin
					next_rx_sub = rx_sub + 4'h1;
					if (rx_sub == ufa_pkg::OVS_MID) begin
						next_rx_cnt = rx_cnt + 4'h1;
						if (rx_cnt == 4'h0 && rx_s2) begin
							next_rx_state = ufa_pkg::RX_IDLE;
						end else if (rx_cnt == tx_last) begin
							rx_fin        = 1'b1;
							next_rx_state = ufa_pkg::RX_IDLE;
						end else if (rx_cnt != 4'h0) begin
							next_rx_sh = {rx_s2, rx_sh[8:1]};
						end
					end
				end
			end
			ufa_pkg::RX_SHIFT: begin
				if (shift_en) begin
					next_rx_sh  = {rx_s2, rx_sh[8:1]};
					next_rx_cnt = rx_cnt + 4'h1;
					if (rx_cnt == ufa_pkg::SHIFT_LAST) begin
						rx_evt        = !serial_control_reg.ri;
						next_rx_state = ufa_pkg::RX_IDLE;
					end
				end
			end
			default: next_rx_state = ufa_pkg::RX_IDLE;
		endcase
		if (rx_fin && !serial_control_reg.ri) begin
			if (!serial_control_reg.sm2)
				rx_evt = 1'b1;
			else if (nine)
				rx_evt = rx_b9 && addr_match;
			else
				rx_evt = rx_s2 && addr_match;
		end
		if (!serial_control_reg.ren)
			next_rx_state = ufa_pkg::RX_IDLE;
	end
	assign fe_evt = rx_fin && !rx_s2;

	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			rx_state <= ufa_pkg::RX_IDLE;
			rx_sh    <= 9'h000;
			rx_cnt   <= 4'h0;
			rx_sub   <= 4'h0;
		end else begin
			rx_state <= next_rx_state;
			rx_sh    <= next_rx_sh;
			rx_cnt   <= next_rx_cnt;
			rx_sub   <= next_rx_sub;
		end
	end

	// register writes, then hardware events so a set beats a clear
	always_comb begin
		next_serial_control_reg    = serial_control_reg;
		next_fe      = fe;
		next_dbl     = dbl;
		next_fsel    = fsel;
		next_slave_address   = slave_address;
		next_slave_address_mask   = slave_address_mask;
		next_sbuf_rx = sbuf_rx;
		next_rdata   = SFR_RDATA;
		if (SFR_REQ.wr) begin
			case (SFR_REQ.addr)
				ufa_pkg::ADDR_PWR: begin
					next_dbl  = SFR_REQ.wdata[ufa_pkg::PWR_DBL];
					next_fsel = SFR_REQ.wdata[ufa_pkg::PWR_FSEL];
				end
				ufa_pkg::ADDR_SERIAL_CONTROL_REG: begin
					next_serial_control_reg = ufa_pkg::ufa_serial_control_reg_s'(SFR_REQ.wdata);
					if (fsel) begin
						next_serial_control_reg.sm0 = serial_control_reg.sm0;
						next_fe       = SFR_REQ.wdata[7];
					end
				end
				ufa_pkg::ADDR_SLAVE_ADDRESS: next_slave_address = SFR_REQ.wdata;
				ufa_pkg::ADDR_SLAVE_ADDRESS_MASK: next_slave_address_mask = SFR_REQ.wdata;
				default: next_sbuf_rx = sbuf_rx;
			endcase
		end
		if (tx_evt)
			next_serial_control_reg.ti = 1'b1;
		if (fe_evt)
			next_fe = 1'b1;
		if (rx_evt) begin
			next_serial_control_reg.ri = 1'b1;
			next_sbuf_rx = rx_byte;
			if (!mode0)
				next_serial_control_reg.rb8 = rx_b9;
		end
		if (SFR_REQ.rd) begin
			case (SFR_REQ.addr)
				ufa_pkg::ADDR_PWR:   next_rdata = {dbl, fsel, 6'h00};
				ufa_pkg::ADDR_SERIAL_CONTROL_REG:  next_rdata = {fsel ? fe : serial_control_reg.sm0, serial_control_reg[6:0]};
				ufa_pkg::ADDR_SBUF:  next_rdata = sbuf_rx;
				ufa_pkg::ADDR_SLAVE_ADDRESS: next_rdata = slave_address;
				ufa_pkg::ADDR_SLAVE_ADDRESS_MASK: next_rdata = slave_address_mask;
				default:             next_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			serial_control_reg      <= ufa_pkg::ufa_serial_control_reg_s'(ufa_pkg::RST_BYTE);
			fe        <= 1'b0;
			dbl       <= 1'b0;
			fsel      <= 1'b0;
			slave_address     <= ufa_pkg::RST_BYTE;
			slave_address_mask     <= ufa_pkg::RST_BYTE;
			sbuf_rx   <= ufa_pkg::RST_BYTE;
			SFR_RDATA <= ufa_pkg::RST_BYTE;
		end else begin
			serial_control_reg      <= next_serial_control_reg;
			fe        <= next_fe;
			dbl       <= next_dbl;
			fsel      <= next_fsel;
			slave_address     <= next_slave_address;
			slave_address_mask     <= next_slave_address_mask;
			sbuf_rx   <= next_sbuf_rx;
			SFR_RDATA <= next_rdata;
		end
	end

	// checks on the behaviour above
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!NRST);
	property p_b7_read;
		SFR_REQ.rd && SFR_REQ.addr == ufa_pkg::ADDR_SERIAL_CONTROL_REG |=> SFR_RDATA[7] == ($past(fsel) ? $past(fe) : $past(serial_control_reg.sm0));
	endproperty
	a_b7_read: assert property (p_b7_read) else $error("bit 7 read mismatch");
	property p_fe_set;
		fe_evt |=> fe;
	endproperty
	a_fe_set: assert property (p_fe_set) else $error("framing error not set");
	property p_fe_hold;
		fe && !(SFR_REQ.wr && SFR_REQ.addr == ufa_pkg::ADDR_SERIAL_CONTROL_REG && fsel) |=> fe;
	endproperty
	a_fe_hold: assert property (p_fe_hold) else $error("framing error lost");
	property p_shift_rate;
		mode0 && shift_en |=> !shift_en [*8];
	endproperty
	a_shift_rate: assert property (p_shift_rate) else $error("shift rate too fast");
	property p_match9;
		rx_fin && nine && serial_control_reg.sm2 && !(rx_b9 && addr_match) |-> !rx_evt ##1 !$rose(serial_control_reg.ri);
	endproperty
	a_match9: assert property (p_match9) else $error("receive flag without address");
	property p_match8;
		rx_fin && !nine && serial_control_reg.sm2 && !(rx_s2 && addr_match) |=> !$rose(serial_control_reg.ri);
	endproperty
	a_match8: assert property (p_match8) else $error("mode 1 flag without match");
	property p_ren_stop;
		!serial_control_reg.ren |=> rx_state == ufa_pkg::RX_IDLE;
	endproperty
	a_ren_stop: assert property (p_ren_stop) else $error("reception while disabled");
	property p_tb8;
		tx_state == ufa_pkg::TX_IDLE && sbuf_wr && !mode0 && nine |=> tx_sh[9] == $past(serial_control_reg.tb8) && tx_sh[0] == 1'b0;
	endproperty
	a_tb8: assert property (p_tb8) else $error("ninth bit not loaded");
	property p_ti;
		tx_evt |=> serial_control_reg.ti && tx_cnt == (mode0 ? ufa_pkg::SHIFT_LAST + 4'h1 : tx_last);
	endproperty
	a_ti: assert property (p_ti) else $error("transmit flag timing");
	property p_ri;
		rx_evt |=> serial_control_reg.ri && sbuf_rx == $past(rx_byte);
	endproperty
	a_ri: assert property (p_ri) else $error("receive flag or data");
	c_rx_match: cover property (rx_evt && serial_control_reg.sm2 && nine);
	c_fe: cover property (fe_evt);
	c_tx0: cover property (tx_evt && mode0);
endmodule // ufa_uart

// ==== verification/ufa_remote.sv ====
// Purpose: remote serial port model facing the device pins
// Assumes: line idles high through its pull-up
// Notes:   tasks are called from the bench by hierarchy
`timescale 1ns/1ps
module ufa_remote (
	input  wire logic clk,
	input  wire logic txd,
	input  wire logic shift_dat,
	output logic      rxd
);
	// idle level of the receive line
	initial rxd = 1'b1;
	// one frame toward the device, start, data lsb first, stop
	task automatic send(input logic [8:0] d, input int nb, input logic stp, input int bl);
		@(posedge clk);
		#1;
		for (int i = -1; i <= nb; i++) begin
			rxd = (i < 0) ? 1'b0 : ((i == nb) ? stp : d[i]);
			repeat (bl) @(posedge clk);
			#1;
		end
		rxd = 1'b1;
	endtask
	// one frame from the device, sampled mid bit
	task automatic recv(input int nb, input int bl, output logic [8:0] d, output logic stp);
		d = '0;
		@(negedge txd);
		repeat (bl / 2) @(posedge clk);
		for (int i = 0; i <= nb; i++) begin
			repeat (bl) @(posedge clk);
			if (i < nb) d[i] = txd;
			else stp = txd;
		end
	endtask
	// shift mode byte, taken on each rising shift clock
	task automatic shift0(output logic [8:0] d);
		d = '0;
		for (int i = 0; i < 8; i++) begin
			@(posedge txd);
			d[i] = shift_dat;
		end
	endtask
	// shift mode byte toward the device, new bit after each falling shift clock
	task automatic shift_in(input logic [7:0] d);
		for (int i = 0; i < 8; i++) begin
			@(negedge txd);
			#1;
			rxd = d[i];
		end
		@(posedge txd);
		repeat (8) @(posedge clk);
		#1;
		rxd = 1'b1;
	endtask
endmodule // ufa_remote

// ==== verification/uart_frame_error_addr_match_tb.sv ====
// Purpose: self-checking bench for the serial port
// Assumes: timer overflow pulses every second clock, so timer modes run 64 clocks a bit without the doubler and 32 with it
// Notes:   remote model drives the receive pin when the device does not
`timescale 1ns/1ps
module uart_frame_error_addr_match_tb;
	logic              clk = 1'b0;
	logic              nrst = 1'b0;
	logic              t1 = 1'b0;
	ufa_pkg::ufa_sfr_s req = '0;
	logic [7:0]        rdata;
	logic              rxo, rxoe, txd, rem_rxd, rxd_pin;
	int                num_errors = 0;
	int                total_checks = 0;
	// clock and timer overflow pulses
	initial forever #20 clk = ~clk;
	always @(posedge clk) #1 t1 = ~t1;
	// two-way receive pin level
	assign rxd_pin = rxoe ? rxo : rem_rxd;
	ufa_uart uut (.CLK_SYS(clk), .NRST(nrst), .SFR_REQ(req), .SFR_RDATA(rdata), .T1_OVF(t1),
		.RXD_IN(rxd_pin), .RXD_OUT(rxo), .RXD_OE(rxoe), .TXD_OUT(txd));
	ufa_remote rem (.clk(clk), .txd(txd), .shift_dat(rxo), .rxd(rem_rxd));
	// compare and count
	task automatic check(input string nm, input logic [8:0] e, input logic [8:0] g);
		total_checks++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// register port write and read
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		#1 req = '{1'b1, 1'b0, a, d};
		@(posedge clk);
		#1 req = '0;
	endtask
	task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
		@(posedge clk);
		#1 req = '{1'b0, 1'b1, a, 8'h00};
		@(posedge clk);
		#1 req = '0;
		check(nm, {1'b0, e & m}, {1'b0, rdata & m});
	endtask
	// reset values and unmapped read
	task automatic t_reset;
		rchk("serial_control_reg", ufa_pkg::ADDR_SERIAL_CONTROL_REG, 8'hFF, 8'h00);
		rchk("addr", ufa_pkg::ADDR_SLAVE_ADDRESS, 8'hFF, 8'h00);
		rchk("mask", ufa_pkg::ADDR_SLAVE_ADDRESS_MASK, 8'hFF, 8'h00);
		rchk("pwr", ufa_pkg::ADDR_PWR, 8'hFF, 8'h00);
		rchk("unmapped", 8'h00, 8'hFF, 8'h00);
	endtask
	// transmit in every mode, the nine-bit modes with and without doubler
	task automatic t_tx;
		logic [8:0] d, e;
		logic       s;
		int         bl, nb;
		logic [1:0] md [5] = '{2'h2, 2'h2, 2'h3, 2'h1, 2'h3};
		for (int i = 0; i < 5; i++) begin
			bl = (i == 1 || i == 4) ? 32 : 64;
			nb = (md[i] == ufa_pkg::MODE_UART8) ? 8 : 9;
			e = (nb == 9) ? {i[0], 8'h5A ^ 8'(i)} : {1'b0, 8'h5A ^ 8'(i)};
			wr(ufa_pkg::ADDR_PWR, (bl == 32) ? 8'h80 : 8'h00);
			wr(ufa_pkg::ADDR_SERIAL_CONTROL_REG, {md[i], 2'b00, i[0], 3'b000});
			fork
				wr(ufa_pkg::ADDR_SBUF, 8'h5A ^ 8'(i));
				rem.recv(nb, bl, d, s);
			join
			check("tx frame", e, d);
			check("tx stop", 9'h001, {8'h00, s});
			rchk("tx flag", ufa_pkg::ADDR_SERIAL_CONTROL_REG, 8'h01, 8'h01);
			repeat (bl) @(posedge clk);
		end
		// shift mode keeps match enable low
		wr(ufa_pkg::ADDR_SERIAL_CONTROL_REG, 8'h00);
		fork
			wr(ufa_pkg::ADDR_SBUF, 8'hC3);
			rem.shift0(d);
		join
		check("shift byte", 9'h0C3, d);
		check("shift drive", 9'h001, {8'h00, rxoe});
		repeat (24) @(posedge clk);
		rchk("shift flag", ufa_pkg::ADDR_SERIAL_CONTROL_REG, 8'h01, 8'h01);
		check("shift release", 9'h000, {8'h00, rxoe});
	endtask
	// receive, framing error flag and bit 7 sharing
	task automatic t_rx;
		wr(ufa_pkg::ADDR_SERIAL_CONTROL_REG, 8'h90);
		wr(ufa_pkg::ADDR_PWR, 8'h40);
		rem.send(9'h03C, 9, 1'b1, 64);
		rchk("rx byte", ufa_pkg::ADDR_SBUF, 8'hFF, 8'h3C);
		rchk("rx serial_control_reg", ufa_pkg::ADDR_SERIAL_CONTROL_REG, 8'hFF, 8'h12);
		wr(ufa_pkg::ADDR_PWR, 8'h00);
		rchk("mode bit", ufa_pkg::ADDR_SERIAL_CONTROL_REG, 8'h80, 8'h80);
		wr(ufa_pkg::ADDR_PWR, 8'h40);
		wr(ufa_pkg::ADDR_SERIAL_CONTROL_REG, 8'h10);
		rem.send(9'h111, 9, 1'b0, 64);
		rchk("fe set", ufa_pkg::ADDR_SERIAL_CONTROL_REG, 8'h80, 8'h80);
		wr(ufa_pkg::ADDR_PWR, 8'h00);
		wr(ufa_pkg::ADDR_SERIAL_CONTROL_REG, 8'h90);
		wr(ufa_pkg::ADDR_PWR, 8'h40);
		rem.send(9'h022, 9, 1'b1, 64);
		rchk("rx good", ufa_pkg::ADDR_SERIAL_CONTROL_REG, 8'h02, 8'h02);
		rchk("fe kept", ufa_pkg::ADDR_SERIAL_CONTROL_REG, 8'h80, 8'h80);
		wr(ufa_pkg::ADDR_SERIAL_CONTROL_REG, 8'h10);
		rchk("fe clear", ufa_pkg::ADDR_SERIAL_CONTROL_REG, 8'h80, 8'h00);
		wr(ufa_pkg::ADDR_PWR, 8'h00);
	endtask
	// address recognition table: control, frame, stop, receive flag
	task automatic t_match;
		logic [18:0] c [8] = '{{8'hB0, 9'h1C2, 2'b11}, {8'hB0, 9'h1C1, 2'b10}, {8'hB0, 9'h0C0, 2'b10},
			{8'hB0, 9'h1FD, 2'b11}, {8'hB0, 9'h1C0, 2'b11}, {8'h70, 9'h0C0, 2'b00},
			{8'h70, 9'h0C2, 2'b11}, {8'h80, 9'h1C0, 2'b10}};
		wr(ufa_pkg::ADDR_SLAVE_ADDRESS, 8'hC0);
		wr(ufa_pkg::ADDR_SLAVE_ADDRESS_MASK, 8'hFD);
		for (int i = 0; i < 8; i++) begin
			wr(ufa_pkg::ADDR_SERIAL_CONTROL_REG, c[i][18:11]);
			rem.send(c[i][10:2], (c[i][18:17] == 2'h1) ? 8 : 9, c[i][1], 64);
			rchk("match flag", ufa_pkg::ADDR_SERIAL_CONTROL_REG, 8'h02, {6'h00, c[i][0], 1'b0});
		end
	endtask
	// shift mode reception with receive enable set
	task automatic t_shift_rx;
		fork
			wr(ufa_pkg::ADDR_SERIAL_CONTROL_REG, 8'h10);
			rem.shift_in(8'hA5);
		join
		rchk("shift rx byte", ufa_pkg::ADDR_SBUF, 8'hFF, 8'hA5);
		rchk("shift rx flag", ufa_pkg::ADDR_SERIAL_CONTROL_REG, 8'h02, 8'h02);
		wr(ufa_pkg::ADDR_SERIAL_CONTROL_REG, 8'h00);
	endtask
	// closing verdict
	task automatic complete_run;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// watchdog against a hang
	initial begin
		repeat (80000) @(posedge clk);
		num_errors++;
		complete_run;
	end
	// main sequence
	initial begin
		repeat (3) @(posedge clk);
		#1 nrst = 1'b1;
		t_reset;
		t_tx;
		t_rx;
		t_match;
		t_shift_rx;
		complete_run;
	end
endmodule // uart_frame_error_addr_match_tb
